// [rtl/pod_pkg.sv]
// Constants, register map and carrier types for the pin override and
// debounce block.
// Assumes a 20 MHz system clock and APB with 32-bit data.
package pod_pkg;

  localparam int PINS      = 16;
  localparam int OVR_FUNCS = 4;
  localparam int PER_W     = 8;
  localparam int SEL_W     = 2;
  localparam int ADDR_W    = 12;

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_MASK0  = 12'h060;
  localparam logic [ADDR_W-1:0] IDX_MASK1  = 12'h062;
  localparam logic [ADDR_W-1:0] IDX_MASK2  = 12'h064;
  localparam logic [ADDR_W-1:0] IDX_MASK3  = 12'h066;
  localparam logic [ADDR_W-1:0] IDX_LEVEL  = 12'h068;
  localparam logic [ADDR_W-1:0] IDX_DIR    = 12'h06A;
  localparam logic [ADDR_W-1:0] IDX_COARSE = 12'h06C;
  localparam logic [ADDR_W-1:0] IDX_MILLI  = 12'h06D;
  localparam logic [ADDR_W-1:0] IDX_MICRO  = 12'h06E;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 12'h06F;
  localparam logic [ADDR_W-1:0] IDX_SELECT = 12'h070;
  localparam int                ADDR_SHIFT = 2;

  // Reset values.
  localparam logic [PINS-1:0]   MASK_RST   = 16'h0000;
  localparam logic [PINS-1:0]   LEVEL_RST  = 16'h0000;
  localparam logic [PINS-1:0]   DIR_RST    = 16'h0000;
  localparam logic [PER_W-1:0]  PERIOD_RST = 8'h0A;
  localparam logic [31:0]       SELECT_RST = 32'h0000_0000;
  localparam int                STATUS_BIT = 0;

  // Timebase figures.
  localparam int CLK_NS      = 50;
  localparam int US_NS       = 1000;
  localparam int US_CYCLES   = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_US       = 1000;
  localparam int TEN_MS_MS   = 10;

  // Per-pin timebase selector codes.
  typedef enum logic [1:0] {
    POD_SEL_OFF    = 2'b00,
    POD_SEL_MICRO  = 2'b01,
    POD_SEL_MILLI  = 2'b10,
    POD_SEL_COARSE = 2'b11
  } pod_sel_t;

  typedef struct packed {
    logic [PER_W-1:0] coarse;
    logic [PER_W-1:0] milli;
    logic [PER_W-1:0] micro;
  } pod_period_t;

  typedef struct packed {
    logic coarse;
    logic milli;
    logic micro;
  } pod_tick_t;

endpackage : pod_pkg

// [rtl/pod_filter.sv]
// One debounce filter for a single pin.
// Assumes a synchronised input and free-running one-cycle tick pulses.
`timescale 1ns/10ps
`default_nettype none
module pod_filter (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         pin_sync,
  input  wire pod_pkg::pod_sel_t            sel,
  input  wire pod_pkg::pod_tick_t           ticks,
  input  wire pod_pkg::pod_period_t         periods,
  output logic                              filt,
  output logic                              pending
);

  logic                       prev_reg;
  logic                       filt_reg;
  logic [pod_pkg::PER_W-1:0]  cnt_reg;
  logic [pod_pkg::PER_W-1:0]  period;
  logic                       tick;

  always_comb
  begin
    period = '0;
    tick   = 1'b0;
    unique case (sel)
      pod_pkg::POD_SEL_OFF:
      begin
        period = '0;
        tick   = 1'b0;
      end
      pod_pkg::POD_SEL_MICRO:
      begin
        period = periods.micro;
        tick   = ticks.micro;
      end
      pod_pkg::POD_SEL_MILLI:
      begin
        period = periods.milli;
        tick   = ticks.milli;
      end
      pod_pkg::POD_SEL_COARSE:
      begin
        period = periods.coarse;
        tick   = ticks.coarse;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prev_reg <= 1'b0;
    else
      prev_reg <= pin_sync;
  end

  // Each input change reloads the count; ticks then count it down.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg  <= '0;
      filt_reg <= 1'b0;
    end
    else if (sel == pod_pkg::POD_SEL_OFF)
    begin
      cnt_reg  <= '0;
      filt_reg <= pin_sync;
    end
    else if (pin_sync != prev_reg)
      cnt_reg <= period;  // see R15
    else if (pin_sync != filt_reg)
    begin
      if (cnt_reg == '0)
        filt_reg <= pin_sync;  // see R9
      else if (tick)
        cnt_reg <= cnt_reg - 1'b1;  // see R10
    end
  end

  assign filt    = filt_reg;
  assign pending = (sel != pod_pkg::POD_SEL_OFF) && (pin_sync != filt_reg);

endmodule : pod_filter
`default_nettype wire

// [rtl/pod_top.sv]
// Pin override mapping and input debounce for a 16-pin I/O bank.
// Assumes APB from software, raw pins from outside and trigger sources
// and normal pin configuration from logic on the same clock.
//
// Functional notes
// R1: Four override functions, each with its own 16-bit pin mask register.
// R2: A masked pin takes its output state from the override, not normal config.
// R3: Several masks may select the same pin; no mask setting is altered.
// R4: Triggered override drives a masked pin's level from the shared level.
// R5: Triggered override sets a masked pin's direction from shared direction.
// R6: Eight-bit period in 10 ms units, reset 0Ah.
// R7: Eight-bit period in 1 ms units, reset 0Ah.
// R8: Eight-bit period in 1 us units, reset 0Ah.
// R9: A transition not stable for the whole period is suppressed.
// R10: Effective debounce time is the count or one count fewer.
// R11: Read-only status bit 0 is 1 while any debounce is pending.
// R12: Two-bit selector per pin: off, microsecond, millisecond, ten-ms.
// R13: Override triggers on source match and holds until disabled.
// R14: A pin masked by any triggered override takes the shared values.
// R15: Free-running prescalers make ticks; each input change restarts a count.
`timescale 1ns/10ps
`default_nettype none
module pod_top #(
  parameter int US_PER_MS    = pod_pkg::MS_US,
  parameter int MS_PER_TEN   = pod_pkg::TEN_MS_MS,
  parameter int CYC_PER_US   = pod_pkg::US_CYCLES
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [pod_pkg::ADDR_W-1:0]    PADDR,
  input  wire logic [31:0]                   PWDATA,
  output logic      [31:0]                   PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  input  wire logic [pod_pkg::PINS-1:0]      PIN_IN,
  input  wire logic [pod_pkg::PINS-1:0]      NORMAL_LEVEL,
  input  wire logic [pod_pkg::PINS-1:0]      NORMAL_DIR,
  input  wire logic [pod_pkg::OVR_FUNCS-1:0] OVERRIDE_ON,
  input  wire logic [pod_pkg::OVR_FUNCS-1:0] SOURCE_MATCH,
  output logic      [pod_pkg::PINS-1:0]      PIN_LEVEL,
  output logic      [pod_pkg::PINS-1:0]      PIN_DIR,
  output logic      [pod_pkg::PINS-1:0]      PIN_FILTERED,
  output logic      [pod_pkg::OVR_FUNCS-1:0] OVERRIDE_TRIGGERED,
  output logic                               FILTER_PENDING
);

  localparam int NP = pod_pkg::PINS;
  localparam int NF = pod_pkg::OVR_FUNCS;
  localparam int SW = pod_pkg::SEL_W;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage.
  logic [NP-1:0]               mask_reg [NF];
  logic [NP-1:0]               level_reg;
  logic [NP-1:0]               dir_reg;
  pod_pkg::pod_period_t        period_reg;
  logic [31:0]                 select_reg;
  logic [NF-1:0]               trig_reg;
  logic                        pending_reg;
  logic [31:0]                 prdata_reg;
  logic                        pready_reg;
  logic                        pslverr_reg;
  logic [NP-1:0]               pin_level_reg;
  logic [NP-1:0]               pin_dir_reg;
  logic [NP-1:0]               filt_reg;
  logic [NP-1:0]               sync1_reg;
  logic [NP-1:0]               sync2_reg;

  logic [NP-1:0]               filt_next;
  logic [NP-1:0]               pend_vec;
  logic [NP-1:0]               hit_next;
  logic [pod_pkg::ADDR_W-1:0]  idx;
  logic                        addr_ok;
  logic                        addr_aligned;
  logic                        wr_take;
  logic [31:0]                 rd_data;
  pod_pkg::pod_sel_t           sel_vec [NP];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.
  assign idx = PADDR >> pod_pkg::ADDR_SHIFT;
  assign addr_aligned = (PADDR[pod_pkg::ADDR_SHIFT-1:0] == '0);
  // A write lands only at the edge where PREADY is sampled high.
  assign wr_take = PSEL && PENABLE && pready_reg && PWRITE;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    addr_ok = addr_aligned;
    unique case (idx)
      pod_pkg::IDX_MASK0:  rd_data[NP-1:0] = mask_reg[0];
      pod_pkg::IDX_MASK1:  rd_data[NP-1:0] = mask_reg[1];
      pod_pkg::IDX_MASK2:  rd_data[NP-1:0] = mask_reg[2];
      pod_pkg::IDX_MASK3:  rd_data[NP-1:0] = mask_reg[3];
      pod_pkg::IDX_LEVEL:  rd_data[NP-1:0] = level_reg;
      pod_pkg::IDX_DIR:    rd_data[NP-1:0] = dir_reg;
      pod_pkg::IDX_COARSE: rd_data[pod_pkg::PER_W-1:0] = period_reg.coarse;
      pod_pkg::IDX_MILLI:  rd_data[pod_pkg::PER_W-1:0] = period_reg.milli;
      pod_pkg::IDX_MICRO:  rd_data[pod_pkg::PER_W-1:0] = period_reg.micro;
      pod_pkg::IDX_STATUS: rd_data[pod_pkg::STATUS_BIT] = pending_reg;  // see R11
      pod_pkg::IDX_SELECT: rd_data = select_reg;
      default:             addr_ok = 1'b0;
    endcase
    if (!addr_aligned)
      rd_data = 32'h0000_0000;
  end

  // One wait state: the answer is ready in the second access cycle.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else if (PSEL && PENABLE && !pready_reg)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= !addr_ok;
      prdata_reg  <= PWRITE ? 32'h0000_0000 : rd_data;
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override mask, level and direction registers.
  genvar gf;
  generate
    for (gf = 0; gf < NF; gf++)
    begin : g_mask
      always_ff @(posedge CLK)
      begin
        if (RST)
          mask_reg[gf] <= pod_pkg::MASK_RST;
        else if (wr_take && addr_ok &&
                 idx == pod_pkg::IDX_MASK0 + pod_pkg::ADDR_W'(2 * gf))
          mask_reg[gf] <= PWDATA[NP-1:0];  // see R1 see R3
      end
    end
  endgenerate

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      level_reg <= pod_pkg::LEVEL_RST;
      dir_reg   <= pod_pkg::DIR_RST;
    end
    else if (wr_take && addr_ok)
    begin
      if (idx == pod_pkg::IDX_LEVEL)
        level_reg <= PWDATA[NP-1:0];
      if (idx == pod_pkg::IDX_DIR)
        dir_reg <= PWDATA[NP-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounce period and selector registers.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      period_reg.coarse <= pod_pkg::PERIOD_RST;  // see R6
      period_reg.milli  <= pod_pkg::PERIOD_RST;  // see R7
      period_reg.micro  <= pod_pkg::PERIOD_RST;  // see R8
    end
    else if (wr_take && addr_ok)
    begin
      if (idx == pod_pkg::IDX_COARSE)
        period_reg.coarse <= PWDATA[pod_pkg::PER_W-1:0];
      if (idx == pod_pkg::IDX_MILLI)
        period_reg.milli <= PWDATA[pod_pkg::PER_W-1:0];
      if (idx == pod_pkg::IDX_MICRO)
        period_reg.micro <= PWDATA[pod_pkg::PER_W-1:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      select_reg <= pod_pkg::SELECT_RST;
    else if (wr_take && addr_ok && idx == pod_pkg::IDX_SELECT)
      select_reg <= PWDATA;  // see R12
  end

  ////////////////////////////////////////////////////////////////////////////
  // Override triggering and output mapping.
  // A disabled function is cleared at once, even in a matching cycle.
  always_ff @(posedge CLK)
  begin
    if (RST)
      trig_reg <= '0;
    else
      trig_reg <= OVERRIDE_ON & (trig_reg | SOURCE_MATCH);  // see R13
  end

  // Any triggered function whose mask holds a pin claims that pin.
  always_comb
  begin
    hit_next = '0;
    for (int f = 0; f < NF; f++)
      hit_next = hit_next | (mask_reg[f] & {NP{trig_reg[f]}});  // see R14
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pin_level_reg <= '0;
      pin_dir_reg   <= '0;
    end
    else
    begin
      // see R2
      pin_level_reg <= (hit_next & level_reg) | (~hit_next & NORMAL_LEVEL);  // see R4
      pin_dir_reg   <= (hit_next & dir_reg) | (~hit_next & NORMAL_DIR);  // see R5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free-running timebase prescalers.
  logic [15:0]           us_cnt_reg;
  logic [15:0]           ms_cnt_reg;
  logic [15:0]           ten_cnt_reg;
  pod_pkg::pod_tick_t    tick_reg;

  // The ticks run free, so a filter may end up to one tick early.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      us_cnt_reg  <= '0;
      ms_cnt_reg  <= '0;
      ten_cnt_reg <= '0;
      tick_reg    <= '0;
    end
    else
    begin
      tick_reg <= '0;
      if (us_cnt_reg == 16'(CYC_PER_US - 1))
      begin
        us_cnt_reg     <= '0;
        tick_reg.micro <= 1'b1;  // see R15
        if (ms_cnt_reg == 16'(US_PER_MS - 1))
        begin
          ms_cnt_reg     <= '0;
          tick_reg.milli <= 1'b1;
          if (ten_cnt_reg == 16'(MS_PER_TEN - 1))
          begin
            ten_cnt_reg     <= '0;
            tick_reg.coarse <= 1'b1;
          end
          else
            ten_cnt_reg <= ten_cnt_reg + 16'h0001;
        end
        else
          ms_cnt_reg <= ms_cnt_reg + 16'h0001;
      end
      else
        us_cnt_reg <= us_cnt_reg + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and per-pin filters.
  // Only the second stage is read; the first may still be settling.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= PIN_IN;
      sync2_reg <= sync1_reg;
    end
  end

  // Split the selector word into one two-bit code per pin.
  always_comb
  begin
    for (int p = 0; p < NP; p++)
      sel_vec[p] = pod_pkg::pod_sel_t'(select_reg[SW*p +: SW]);  // see R12
  end

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++)
    begin : g_pin
      pod_filter u_filter (
        .clk      (CLK),
        .rst      (RST),
        .pin_sync (sync2_reg[gp]),
        .sel      (sel_vec[gp]),
        .ticks    (tick_reg),
        .periods  (period_reg),
        .filt     (filt_next[gp]),
        .pending  (pend_vec[gp])
      );
    end
  endgenerate

  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      filt_reg    <= '0;
      pending_reg <= 1'b0;
    end
    else
    begin
      filt_reg    <= filt_next;
      pending_reg <= |pend_vec;  // see R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign PRDATA             = prdata_reg;
  assign PREADY             = pready_reg;
  assign PSLVERR            = pslverr_reg;
  assign PIN_LEVEL          = pin_level_reg;
  assign PIN_DIR            = pin_dir_reg;
  assign PIN_FILTERED       = filt_reg;
  assign OVERRIDE_TRIGGERED = trig_reg;
  assign FILTER_PENDING     = pending_reg;

endmodule : pod_top
`default_nettype wire

// [tb/pod_checker.sv]
// Concurrent checks on the ports of the pin override and debounce block.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module pod_checker (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic [31:0] PRDATA,
  input  wire logic        PREADY,
  input  wire logic        PSLVERR,
  input  wire logic [15:0] PIN_IN,
  input  wire logic [15:0] NORMAL_LEVEL,
  input  wire logic [15:0] NORMAL_DIR,
  input  wire logic [3:0]  OVERRIDE_ON,
  input  wire logic [3:0]  SOURCE_MATCH,
  input  wire logic [15:0] PIN_LEVEL,
  input  wire logic [15:0] PIN_DIR,
  input  wire logic [15:0] PIN_FILTERED,
  input  wire logic [3:0]  OVERRIDE_TRIGGERED,
  input  wire logic        FILTER_PENDING
);
  logic [3:0] arm;
  assign arm = OVERRIDE_ON & SOURCE_MATCH;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; PSEL && PENABLE && !PREADY; endsequence
  property p_ready_wait; s_setup ##1 s_access |=> PREADY; endproperty
  property p_ready_pulse; PREADY |=> !PREADY; endproperty
  property p_err_ready; PSLVERR |-> PREADY; endproperty
  property p_rdata_idle; !PREADY |-> PRDATA == 32'h0; endproperty
  property p_trig_set;
    arm != 4'h0 |=> (OVERRIDE_TRIGGERED & $past(arm)) == $past(arm);
  endproperty
  property p_trig_clr;
    OVERRIDE_ON != 4'hF |=> (OVERRIDE_TRIGGERED & ~$past(OVERRIDE_ON)) == 4'h0;
  endproperty
  property p_idle_level;
    OVERRIDE_TRIGGERED == 4'h0 |=> PIN_LEVEL == $past(NORMAL_LEVEL);
  endproperty
  property p_idle_dir;
    OVERRIDE_TRIGGERED == 4'h0 |=> PIN_DIR == $past(NORMAL_DIR);
  endproperty
  property p_pend_idle;
    (PIN_IN == PIN_FILTERED) [*6] |-> !FILTER_PENDING;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_ready_wait: assert property (p_ready_wait)
    else $error("Answer not in second access cycle.");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("Ready held longer than one cycle.");
  a_err_ready: assert property (p_err_ready)
    else $error("Error flag without ready.");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data not zero outside answer.");
  a_trig_set: assert property (p_trig_set)
    else $error("Override not triggered on match.");
  a_trig_clr: assert property (p_trig_clr)
    else $error("Override flag kept while disabled.");
  a_idle_level: assert property (p_idle_level)
    else $error("Level differs from normal with no override.");
  a_idle_dir: assert property (p_idle_dir)
    else $error("Direction differs from normal with no override.");
  a_pend_idle: assert property (p_pend_idle)
    else $error("Pending flag set with nothing to filter.");
endmodule : pod_checker
bind pod_top pod_checker u_checker (.CLK, .RST, .PSEL, .PENABLE, .PRDATA,
  .PREADY, .PSLVERR, .PIN_IN, .NORMAL_LEVEL, .NORMAL_DIR, .OVERRIDE_ON,
  .SOURCE_MATCH, .PIN_LEVEL, .PIN_DIR, .PIN_FILTERED, .OVERRIDE_TRIGGERED,
  .FILTER_PENDING);
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the pin override and debounce block.
// Assumes pod_top with shortened timebases and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int CPU = 2;
  localparam int UPM = 3;
  localparam int MPT = 2;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [15:0] pin_in  = 16'h0000;
  logic [15:0] nlev    = 16'h1234;
  logic [15:0] ndir    = 16'hFFFF;
  logic [3:0]  ovr_on  = 4'h0;
  logic [3:0]  match   = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] plev;
  logic [15:0] pdir;
  logic [15:0] pfilt;
  logic [3:0]  trig;
  logic        pend;
  int          n_errors = 0;
  int          compares = 0;
  pod_top #(.US_PER_MS(UPM), .MS_PER_TEN(MPT), .CYC_PER_US(CPU)) DUT (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(pin_in), .NORMAL_LEVEL(nlev),
    .NORMAL_DIR(ndir), .OVERRIDE_ON(ovr_on), .SOURCE_MATCH(match),
    .PIN_LEVEL(plev), .PIN_DIR(pdir), .PIN_FILTERED(pfilt),
    .OVERRIDE_TRIGGERED(trig), .FILTER_PENDING(pend));
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d.", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic logic [11:0] ba(input logic [11:0] i);
    return i << pod_pkg::ADDR_SHIFT;
  endfunction : ba
  function automatic logic [15:0] mix(input logic [15:0] n, o, m);
    return (n & ~m) | (o & m);
  endfunction : mix
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(negedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    q = prdata;
    e = pslverr;
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    chk("apb_wait", n < 20, 1'b1);
    @(posedge clk);
  endtask : apb
  task automatic wait_f(input logic v, output int n);
    n = 0;
    while (pfilt[0] !== v && n < 400)
    begin
      @(negedge clk);
      n++;
    end
    chk("filter_wait", n < 400, 1'b1);
    @(posedge clk);
  endtask : wait_f
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [11:0] ix [11] = '{pod_pkg::IDX_MASK0, pod_pkg::IDX_MASK1,
      pod_pkg::IDX_MASK2, pod_pkg::IDX_MASK3, pod_pkg::IDX_LEVEL,
      pod_pkg::IDX_DIR, pod_pkg::IDX_COARSE, pod_pkg::IDX_MILLI,
      pod_pkg::IDX_MICRO, pod_pkg::IDX_STATUS, pod_pkg::IDX_SELECT};
    logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0A, 32'h0A, 32'h0A, 32'h0, 32'h0};
    logic [31:0] wm [11] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
      32'hFFFF, 32'hFFFF, 32'hFF, 32'hFF, 32'hFF, 32'h0, 32'hFFFFFFFF};
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 11; i++)
    begin
      apb(1'b0, ba(ix[i]), 32'h0, q, e);
      chk("reset_value", q, rv[i]);
      apb(1'b1, ba(ix[i]), 32'hFFFFFFFF, q, e);
      apb(1'b0, ba(ix[i]), 32'h0, q, e);
      chk("readback", q, wm[i]);
      apb(1'b1, ba(ix[i]), rv[i], q, e);
    end
    apb(1'b0, 12'h1C4, 32'h0, q, e);
    chk("unmapped_err", e, 1'b1);
    apb(1'b1, 12'h182, 32'h1, q, e);
    chk("misaligned_err", e, 1'b1);
  endtask : t_regs
  task automatic t_override;
    logic [31:0] q;
    logic        e;
    apb(1'b1, ba(pod_pkg::IDX_MASK0), 32'h00F0, q, e);
    apb(1'b1, ba(pod_pkg::IDX_MASK1), 32'h0030, q, e);
    apb(1'b1, ba(pod_pkg::IDX_LEVEL), 32'hA5A5, q, e);
    apb(1'b1, ba(pod_pkg::IDX_DIR), 32'h0F0F, q, e);
    ovr_on <= 4'h3;
    match <= 4'h2;
    @(posedge clk);
    match <= 4'h0;
    repeat (4) @(posedge clk);
    chk("trig_one", trig, 4'h2);
    chk("level_one", plev, mix(nlev, 16'hA5A5, 16'h0030));
    chk("dir_one", pdir, mix(ndir, 16'h0F0F, 16'h0030));
    match <= 4'h1;
    @(posedge clk);
    match <= 4'h0;
    repeat (4) @(posedge clk);
    chk("trig_two", trig, 4'h3);
    chk("level_two", plev, mix(nlev, 16'hA5A5, 16'h00F0));
    ovr_on <= 4'h1;
    repeat (4) @(posedge clk);
    chk("level_shared", plev, mix(nlev, 16'hA5A5, 16'h00F0));
    chk("dir_shared", pdir, mix(ndir, 16'h0F0F, 16'h00F0));
    apb(1'b0, ba(pod_pkg::IDX_MASK1), 32'h0, q, e);
    chk("mask_kept", q, 32'h0030);
    ovr_on <= 4'h0;
    repeat (4) @(posedge clk);
    chk("level_normal", plev, nlev);
    chk("trig_clear", trig, 4'h0);
  endtask : t_override
  task automatic t_select;
    int          per [4] = '{0, CPU, CPU * UPM, CPU * UPM * MPT};
    logic [31:0] q;
    logic        e;
    int          n;
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, ba(pod_pkg::IDX_SELECT), c, q, e);
      pin_in[0] <= 1'b1;
      wait_f(1'b1, n);
      chk("filter_min", n >= 9 * per[c], 1'b1);
      chk("filter_max", n <= 10 * per[c] + 8, 1'b1);
      pin_in[0] <= 1'b0;
      wait_f(1'b0, n);
    end
  endtask : t_select
  task automatic t_glitch;
    logic [31:0] q;
    logic        e;
    apb(1'b1, ba(pod_pkg::IDX_SELECT), 32'h00C0, q, e);
    pin_in[3] <= 1'b1;
    repeat (6) @(posedge clk);
    chk("pending_port", pend, 1'b1);
    apb(1'b0, ba(pod_pkg::IDX_STATUS), 32'h0, q, e);
    chk("pending_reg", q, 32'h1);
    chk("glitch_held", pfilt, 16'h0000);
    pin_in[3] <= 1'b0;
    repeat (130) @(posedge clk);
    chk("glitch_blocked", pfilt, 16'h0000);
    apb(1'b0, ba(pod_pkg::IDX_STATUS), 32'h0, q, e);
    chk("pending_clear", q, 32'h0);
  endtask : t_glitch
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_override;
    t_select;
    t_glitch;
    stop_test;
  end
  initial
  begin
    #400000;
    n_errors++;
    stop_test;
  end
endmodule : testbench
`default_nettype wire
